//--- dam_pkg.sv
// Purpose: shared constants and types of the dram address multiplexer
// Assumes: one 25 MHz clock, synchronous active-low reset
// Notes: port-width codes are the encoding used on the per-cs inputs
package dam_pkg;

  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int LOG_ADDR_W = 28;   // bus address width
  localparam int MUX_PINS = 14;     // multiplexed low address pins
  localparam int CS_COUNT = 5;      // chip selects
  localparam int CS_IDX_W = 3;      // chip select index width
  localparam int CLOCK_MHZ = 25;    // bus clock rate

  // ---------------------------------------------------------------
  // field positions and values
  // ---------------------------------------------------------------
  localparam int COL_ZERO_MSB = 13; // pins forced low in mode 1 column
  localparam int COL_ZERO_LSB = 11;
  localparam logic [1:0] WIDTH_32 = 2'h0;
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] WIDTH_16 = 2'h2;
  localparam logic MODE_0 = 1'h0;
  localparam logic MODE_1 = 1'h1;
  localparam logic [LOG_ADDR_W-1:0] ADDR_RESET = 28'h0000000;
  localparam logic [CS_IDX_W-1:0] CS_DEFAULT = 3'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ROW,
    PH_COL
  } dam_phase_t;

endpackage : dam_pkg

//--- dam_core_if.sv
// Purpose: carrier between the address multiplexer and its helpers
// Assumes: all signals on the single bus clock
// Notes: mapper is pure logic, sequencer holds the access phase
`timescale 1ns/10ps
interface dam_core_if;
  import dam_pkg::*;

  logic [LOG_ADDR_W-1:0] addr;   // logical address for the mapper
  logic mode;                    // multiplexing mode of the access
  logic [1:0] width;             // port width code of the access
  logic col;                     // column mapping wanted
  logic [MUX_PINS-1:0] mux_addr; // mapped low pins
  logic start;                   // access begins
  logic col_req;                 // move to column phase
  logic end_req;                 // access ends
  dam_phase_t phase;             // current phase
  dam_phase_t next_phase;        // phase after this edge

  modport mapper (input addr, mode, width, col, output mux_addr);
  modport seq (input start, col_req, end_req,
               output phase, next_phase);
  modport user (output addr, mode, width, col, start, col_req, end_req,
                input mux_addr, phase, next_phase);
endinterface : dam_core_if

//--- dam_addr_map.sv
// Purpose: row and column mapping of the logical address onto 14 pins
// Assumes: inputs stable within the cycle
// Notes: pins with no assignment in a mapping drive zero
`timescale 1ns/10ps
module dam_addr_map
  import dam_pkg::*;
(
  dam_core_if.mapper core // mapping request and result
);

  // ---------------------------------------------------------------
  // mapping table selected by mode and width
  // ---------------------------------------------------------------
  // mode bit and width pick the table, col picks the phase
  always_comb begin // R18
    logic [LOG_ADDR_W-1:0] a;
    a = core.addr;
    core.mux_addr = '0;
    if (core.mode == MODE_0) begin
      case (core.width) // R12 R3
        WIDTH_8: begin
          if (!core.col) begin
            core.mux_addr[11] = a[18];
            core.mux_addr[8:4] = a[17:13];
            core.mux_addr[3] = a[11];
            core.mux_addr[2] = a[12];
            core.mux_addr[1:0] = a[10:9];
          end else begin
            core.mux_addr[11] = a[19];
            core.mux_addr[8:0] = a[8:0];
          end
        end
        WIDTH_16: begin
          core.mux_addr[12] = core.col ? a[20] : a[19];
          core.mux_addr[9:1] = core.col ? a[9:1] : a[18:10];
        end
        default: begin
          core.mux_addr[13] = core.col ? a[21] : a[20];
          core.mux_addr[10:2] = core.col ? a[10:2] : a[19:11];
        end
      endcase
    end else begin
      case (core.width) // R3
        WIDTH_8: begin // R13
          core.mux_addr = core.col ?
            {3'h0, a[10], a[20], a[19], a[7:0]} : a[21:8];
        end
        WIDTH_16: begin // R14 R9
          core.mux_addr[13:1] = core.col ? {3'h0, a[10:1]} : a[21:9];
        end
        default: begin // R15 R9
          core.mux_addr[13:2] = core.col ? {3'h0, a[10:2]} : a[21:10];
        end
      endcase
    end
  end

endmodule : dam_addr_map

//--- dam_phase_ctrl.sv
// Purpose: row then column phase of each dram access
// Assumes: strobes come from the dram cycle state machine
// Notes: end wins over a column request in the same cycle
`timescale 1ns/10ps
module dam_phase_ctrl
  import dam_pkg::*;
(
  input wire logic clock, // bus clock
  input wire logic rst_n, // synchronous reset, active low
  dam_core_if.seq core    // phase strobes and state
);

  // ---------------------------------------------------------------
  // next phase
  // ---------------------------------------------------------------
  // row always comes first, column only after row
  always_comb begin // R8 R18
    core.next_phase = core.phase;
    case (core.phase)
      PH_IDLE: if (core.start) core.next_phase = PH_ROW;
      PH_ROW: begin
        if (core.end_req) core.next_phase = PH_IDLE;
        else if (core.col_req) core.next_phase = PH_COL;
      end
      PH_COL: if (core.end_req) core.next_phase = PH_IDLE;
      default: core.next_phase = PH_IDLE;
    endcase
  end

  // phase register
  always_ff @(posedge clock) begin
    if (!rst_n) core.phase <= PH_IDLE;
    else core.phase <= core.next_phase;
  end

endmodule : dam_phase_ctrl

//--- dam_address_mux.sv
// Purpose: per chip select dram row/column address multiplexer
// Assumes: strobes from the dram cycle state machine, one clock
// Notes: all outputs are registered and follow the phase register
//
// Contract
// R1: internal or external mux chosen by two global bits and per-cs bit; the code uses only global_external_mux_select and the per-cs bit.
// R2: internal mux presents row and column on the 14 low address pins.
// R3: mapping aligned to port width: 32 from A2, 16 from A1, 8 from A0.
// R4: memories with fewer address inputs use the low mux pins only.
// R5: sdram bank selects wire to upper unmultiplexed pins, never A13..A0.
// R6: two internal modes, selected per chip select independently.
// R7: software must pick mode one for every sdram chip select.
// R8: each access drives row part first, then column part on same pins.
// R9: mode one column phase drives A13, A12, A11 low for all widths.
// R10: upper unmultiplexed pins stay unchanged through row and column.
// R11: sdram A10/auto-precharge wires to the lowest column strobe pin.
// R12: mode zero multiplexes 20 bits; 8-bit A11 carries 18 then 19.
// R13: mode one 8-bit: row 21..8; column 0,0,0,10,20,19,7..0.
// R14: mode one 16-bit: row 22..9; column 22, zeros, 10..1.
// R15: mode one 32-bit: row 23..10; column 23, 22, zeros, 10..2.
// R16: external mux: plain address on bus plus indicator on its pin.
// R17: indicator high in fp/edo column and sdram commands, else low.
// R18: dram state machine switches phase; cs mode and width pick map.
`timescale 1ns/10ps
module dam_address_mux
  import dam_pkg::*;
(
  input wire logic clock,                         // 25 MHz bus clock
  input wire logic rst_n,                         // sync reset, low
  input wire logic global_external_mux_select,    // all cs external
  input wire logic mux_indicator_force,           // indicator, internal
  input wire logic [CS_COUNT-1:0] cs_external_mux_select, // per cs ext
  input wire logic [CS_COUNT-1:0] cs_mux_mode_select,     // per cs mode
  input wire logic [CS_COUNT-1:0] cs_sdram_select,        // cs is sdram
  input wire logic [2*CS_COUNT-1:0] cs_port_width,        // 2 bits / cs
  input wire logic [CS_IDX_W-1:0] cs_index,       // active chip select
  input wire logic [LOG_ADDR_W-1:0] logical_addr, // bus address
  input wire logic cycle_start,                   // access begins
  input wire logic column_phase_req,              // go to column
  input wire logic cycle_end,                     // access done
  input wire logic sdram_command,                 // sdram rd/wr/lmr
  output logic [LOG_ADDR_W-1:0] addr_out,         // address pins
  output logic mux_indicator_pin,                 // mux indicator
  output logic mux_indicator_enable,              // indicator driven
  output logic external_mux_active,               // plain address used
  output logic column_phase                       // column on pins
);

  // ---------------------------------------------------------------
  // helpers and carrier
  // ---------------------------------------------------------------
  dam_core_if core ();

  dam_addr_map u_map (
    .core(core)
  );

  dam_phase_ctrl u_phase (
    .clock(clock),
    .rst_n(rst_n),
    .core(core)
  );

  // ---------------------------------------------------------------
  // access settings captured at cycle start
  // ---------------------------------------------------------------
  logic [LOG_ADDR_W-1:0] lat_addr;
  logic lat_mode;
  logic [1:0] lat_width;
  logic lat_ext;
  logic lat_ind_en;
  logic lat_sdram;
  logic [LOG_ADDR_W-1:0] next_lat_addr;
  logic next_lat_mode;
  logic [1:0] next_lat_width;
  logic next_lat_ext;
  logic next_lat_ind_en;
  logic next_lat_sdram;
  logic [CS_IDX_W-1:0] cs_sel;
  logic take;

  // out-of-range index falls back to the first chip select
  assign cs_sel = (cs_index < CS_IDX_W'(CS_COUNT)) ? cs_index : CS_DEFAULT;
  assign take = (core.phase == PH_IDLE) && cycle_start;

  // pick the active chip select's bits at the start of an access
  always_comb begin
    next_lat_addr = lat_addr;
    next_lat_mode = lat_mode;
    next_lat_width = lat_width;
    next_lat_ext = lat_ext;
    next_lat_ind_en = lat_ind_en;
    next_lat_sdram = lat_sdram;
    if (take) begin
      next_lat_addr = logical_addr; // R10
      next_lat_mode = cs_mux_mode_select[cs_sel]; // R6
      next_lat_width = cs_port_width[2*cs_sel +: 2]; // R3
      next_lat_ext = global_external_mux_select
                   | cs_external_mux_select[cs_sel]; // R1
      next_lat_ind_en = global_external_mux_select | mux_indicator_force
                      | cs_external_mux_select[cs_sel]; // R1 R16
      next_lat_sdram = cs_sdram_select[cs_sel];
    end
  end

  // settings registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lat_addr <= ADDR_RESET;
      lat_mode <= MODE_0;
      lat_width <= WIDTH_32;
      lat_ext <= 1'h0;
      lat_ind_en <= 1'h0;
      lat_sdram <= 1'h0;
    end else begin
      lat_addr <= next_lat_addr;
      lat_mode <= next_lat_mode;
      lat_width <= next_lat_width;
      lat_ext <= next_lat_ext;
      lat_ind_en <= next_lat_ind_en;
      lat_sdram <= next_lat_sdram;
    end
  end

  // ---------------------------------------------------------------
  // phase strobes and mapper request
  // ---------------------------------------------------------------
  // mapper sees the settings that will hold after this edge
  always_comb begin // R18
    core.start = cycle_start;
    core.col_req = column_phase_req;
    core.end_req = cycle_end;
    core.addr = next_lat_addr;
    core.mode = next_lat_mode;
    core.width = next_lat_width;
    core.col = (core.next_phase == PH_COL);
  end

  // ---------------------------------------------------------------
  // pin values
  // ---------------------------------------------------------------
  logic [LOG_ADDR_W-1:0] next_addr_out;
  logic next_ind;
  logic next_ind_en;
  logic next_ext;
  logic next_col;
  logic busy;

  assign busy = (core.next_phase != PH_IDLE);

  // in an access upper pins carry the captured address, low pins the map if internal; idle passes the bus address
  always_comb begin
    next_addr_out = busy ? next_lat_addr : logical_addr; // R10 R16
    if (busy && !next_lat_ext) begin
      next_addr_out[MUX_PINS-1:0] = core.mux_addr; // R2 R8
    end
    next_ext = busy && next_lat_ext; // R1
    next_col = (core.next_phase == PH_COL);
    next_ind_en = busy ? next_lat_ind_en : lat_ind_en;
    // fp/edo: column phase; sdram: its read, write, load-mode commands
    next_ind = next_ind_en && busy
             && (next_lat_sdram ? sdram_command : next_col); // R17
  end

  // output registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      addr_out <= ADDR_RESET;
      mux_indicator_pin <= 1'h0;
      mux_indicator_enable <= 1'h0;
      external_mux_active <= 1'h0;
      column_phase <= 1'h0;
    end else begin
      addr_out <= next_addr_out;
      mux_indicator_pin <= next_ind;
      mux_indicator_enable <= next_ind_en;
      external_mux_active <= next_ext;
      column_phase <= next_col;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic internal;
  assign internal = (core.phase != PH_IDLE) && !lat_ext;

  sequence s_row;
    core.phase == PH_ROW;
  endsequence

  sequence s_col_entry;
    core.phase == PH_COL && $past(core.phase) == PH_ROW;
  endsequence

  a_col_after_row: assert property ( // R8
    core.phase == PH_COL |-> $past(core.phase) != PH_IDLE)
    else $error("column phase entered without row phase");

  a_col_top_zero: assert property ( // R9
    internal && column_phase && lat_mode == MODE_1
    |-> addr_out[COL_ZERO_MSB:COL_ZERO_LSB] == 3'h0)
    else $error("mode 1 column pins 13..11 not zero");

  a_upper_stable: assert property ( // R10
    s_row ##1 (core.phase != PH_IDLE)
    |-> addr_out[LOG_ADDR_W-1:MUX_PINS]
    == $past(addr_out[LOG_ADDR_W-1:MUX_PINS]))
    else $error("upper address pins moved inside an access");

  a_ext_plain: assert property ( // R16
    (core.phase != PH_IDLE) && lat_ext
    |-> addr_out == lat_addr && external_mux_active)
    else $error("external mux access not plain address");

  a_ind_idle_low: assert property ( // R17
    core.phase == PH_IDLE |-> !mux_indicator_pin)
    else $error("indicator high outside an access");

  a_ind_fp_col: assert property ( // R17
    s_col_entry ##0 (lat_ind_en && !lat_sdram) |-> mux_indicator_pin)
    else $error("indicator low in fp/edo column phase");

  a_m0_row_col: assert property ( // R12
    internal && lat_mode == MODE_0 && lat_width == WIDTH_8 ##0 s_row
    ##1 s_col_entry |-> addr_out[11] == lat_addr[19]
    && $past(addr_out[11]) == lat_addr[18])
    else $error("mode 0 8-bit pin 11 mapping wrong");

  a_m1_8_map: assert property ( // R13
    internal && lat_mode == MODE_1 && lat_width == WIDTH_8 ##0 s_col_entry
    |-> addr_out[10:8] == {lat_addr[10], lat_addr[20], lat_addr[19]}
    && $past(addr_out[13:0]) == lat_addr[21:8])
    else $error("mode 1 8-bit mapping wrong");

  a_m1_16_col: assert property ( // R14
    internal && lat_mode == MODE_1 && lat_width == WIDTH_16
    && column_phase |-> addr_out[10:1] == lat_addr[10:1]
    && addr_out[22] == lat_addr[22])
    else $error("mode 1 16-bit column mapping wrong");

  a_m1_32_row: assert property ( // R15 R3
    internal && lat_mode == MODE_1 && lat_width == WIDTH_32 ##0 s_row
    |-> addr_out[13:2] == lat_addr[21:10] && addr_out[1:0] == 2'h0)
    else $error("mode 1 32-bit row mapping wrong");

  a_mode_taken: assert property ( // R6 R1
    take |=> lat_mode == $past(cs_mux_mode_select[cs_sel])
    && lat_ext == $past(global_external_mux_select
    | cs_external_mux_select[cs_sel]))
    else $error("per chip select settings not captured");

  a_m0_16_map: assert property ( // R12 R3
    internal && lat_mode == MODE_0 && lat_width == WIDTH_16 ##0 s_col_entry
    |-> addr_out[12] == lat_addr[20] && addr_out[9:1] == lat_addr[9:1]
    && $past(addr_out[12]) == lat_addr[19]
    && $past(addr_out[9:1]) == lat_addr[18:10])
    else $error("mode 0 16-bit mapping wrong");

  a_m0_32_map: assert property ( // R12 R3
    internal && lat_mode == MODE_0 && lat_width == WIDTH_32 ##0 s_col_entry
    |-> addr_out[13] == lat_addr[21] && addr_out[10:2] == lat_addr[10:2]
    && $past(addr_out[13]) == lat_addr[20]
    && $past(addr_out[10:2]) == lat_addr[19:11])
    else $error("mode 0 32-bit mapping wrong");

  a_m1_16_row: assert property ( // R14 R3
    internal && lat_mode == MODE_1 && lat_width == WIDTH_16 ##0 s_row
    |-> addr_out[13:1] == lat_addr[21:9] && addr_out[0] == 1'h0)
    else $error("mode 1 16-bit row mapping wrong");

  a_m1_32_col: assert property ( // R15 R9
    internal && lat_mode == MODE_1 && lat_width == WIDTH_32
    && column_phase |-> addr_out[10:2] == lat_addr[10:2]
    && addr_out[23:22] == lat_addr[23:22] && addr_out[1:0] == 2'h0)
    else $error("mode 1 32-bit column mapping wrong");

  a_ind_sdram: assert property ( // R17
    (core.phase != PH_IDLE) && lat_ind_en && lat_sdram
    |-> mux_indicator_pin == $past(sdram_command))
    else $error("indicator does not follow sdram command");

  a_ind_row_low: assert property ( // R17
    core.phase == PH_ROW && !lat_sdram |-> !mux_indicator_pin)
    else $error("indicator high in fp/edo row phase");

  a_idle_flags: assert property ( // R1 R8
    core.phase == PH_IDLE |-> !external_mux_active && !column_phase)
    else $error("access flags high while idle");

  a_int_plain_off: assert property ( // R1 R2
    internal |-> !external_mux_active)
    else $error("external flag high in internal access");

  a_start_row: assert property ( // R8
    core.phase == PH_IDLE && cycle_start |=> core.phase == PH_ROW
    && !column_phase)
    else $error("access did not open with the row phase");

  a_end_idle: assert property ( // R8 R18
    core.phase != PH_IDLE && cycle_end |=> core.phase == PH_IDLE)
    else $error("access did not close on its end strobe");

  a_col_switch: assert property ( // R18
    s_row ##0 (column_phase_req && !cycle_end) |=> column_phase)
    else $error("row did not switch to column on request");

endmodule : dam_address_mux

//--- dam_dram_model.sv
// Purpose: far-side dram model watching the multiplexed address pins
// Assumes: bench marks the span of each access on in_access
// Notes: flags any change of the bank pins inside one access
`timescale 1ns/10ps
module dam_dram_model
  import dam_pkg::*;
#(
  parameter int ROW_PINS = 14 // address inputs of the memory
)
(
  input wire logic clock,                   // bus clock
  input wire logic rst_n,                   // sync reset, low
  input wire logic [LOG_ADDR_W-1:0] pins,   // device address pins
  input wire logic column_phase,            // column on the pins
  input wire logic in_access,               // access in progress
  output logic bank_changed,                // bank pins moved
  output logic [ROW_PINS-1:0] row_seen,     // row latched by memory
  output logic [ROW_PINS-1:0] col_seen      // column latched by memory
);
  logic [2:0] bank;
  logic bank_valid;

  // only the low pins feed the memory, upper mux pins stay open
  // banks sit on A23..A21, never on a mux pin
  // auto-precharge comes from a column strobe, not these pins
  always @(posedge clock) begin
    if (!rst_n) begin
      bank_valid <= 1'b0;
      bank_changed <= 1'b0;
    end else if (!in_access) begin
      bank_valid <= 1'b0;
    end else begin
      if (!bank_valid) begin
        bank <= pins[23:21];
        bank_valid <= 1'b1;
      end else if (pins[23:21] !== bank) begin
        bank_changed <= 1'b1;
      end
      if (column_phase) col_seen <= pins[ROW_PINS-1:0];
      else row_seen <= pins[ROW_PINS-1:0];
    end
  end
endmodule : dam_dram_model

//--- tb_top.sv
// Purpose: self-checking bench of the dram address multiplexer
// Assumes: inputs driven at the falling edge, outputs settled there
// Notes: random chip select setups with fixed seed, corners first
`timescale 1ns/10ps
module tb_top
  import dam_pkg::*;
;
  logic clock, rst_n, gext, frc, st, cr, ce, sc, in_acc;
  logic [4:0] csx, csm, css;
  logic [9:0] csw;
  logic [2:0] idx;
  logic [27:0] la, ao;
  logic ind, ien, xa, cp, bc;
  logic [13:0] mrow, mcol;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  dam_address_mux DUT (.clock(clock), .rst_n(rst_n),
    .global_external_mux_select(gext), .mux_indicator_force(frc),
    .cs_external_mux_select(csx), .cs_mux_mode_select(csm),
    .cs_sdram_select(css), .cs_port_width(csw), .cs_index(idx),
    .logical_addr(la), .cycle_start(st), .column_phase_req(cr),
    .cycle_end(ce), .sdram_command(sc), .addr_out(ao),
    .mux_indicator_pin(ind), .mux_indicator_enable(ien),
    .external_mux_active(xa), .column_phase(cp));

  dam_dram_model #(.ROW_PINS(MUX_PINS)) u_dram (.clock(clock),
    .rst_n(rst_n), .pins(ao), .column_phase(cp), .in_access(in_acc),
    .bank_changed(bc), .row_seen(mrow), .col_seen(mcol));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // expected low pins for internal mapping
  function automatic logic [13:0] exp_map(logic [27:0] a, logic m,
                                          logic [1:0] w, logic c);
    if (m == MODE_1) begin
      case (w)
        WIDTH_8: return c ? {3'h0, a[10], a[20], a[19], a[7:0]} : a[21:8];
        WIDTH_16: return c ? {3'h0, a[10:1], 1'h0} : {a[21:9], 1'h0};
        default: return c ? {3'h0, a[10:2], 2'h0} : {a[21:10], 2'h0};
      endcase
    end
    case (w)
      WIDTH_8: return c ? {2'h0, a[19], 2'h0, a[8:0]} :
        {2'h0, a[18], 2'h0, a[17:13], a[11], a[12], a[10], a[9]};
      WIDTH_16: return c ? {1'h0, a[20], 2'h0, a[9:1], 1'h0} :
        {1'h0, a[19], 2'h0, a[18:10], 1'h0};
      default: return c ? {a[21], 2'h0, a[10:2], 2'h0} :
        {a[20], 2'h0, a[19:11], 2'h0};
    endcase
  endfunction : exp_map

  // one access: row, optional column, end; cut resets in mid-access
  task automatic run_access(input int i, input bit cut);
    logic [13:0] lo;
    logic [27:0] a;
    logic md, ex, en, sd, dc;
    logic [1:0] w;
    int e;
    @(negedge clock);
    a = $urandom;
    gext = ($urandom % 4) == 0;
    frc = $urandom;
    csx = $urandom;
    css = $urandom;
    csw = $urandom;
    idx = $urandom;
    csm = $urandom | css;
    if (i < 8) begin
      gext = 1'b0;
      csx = 5'h00;
      csm = {5{i[0]}};
      css = 5'h00;
      csw = {5{i[2:1]}};
      a = 28'h5a5a5a5 ^ 28'(i);
    end
    la = a;
    st = 1'b1;
    e = (idx > 4) ? 0 : int'(idx);
    ex = gext | csx[e];
    md = csm[e];
    sd = css[e];
    w = csw[2*e +: 2];
    en = ex | frc;
    @(negedge clock);
    st = $urandom;
    la = $urandom;
    sc = $urandom;
    in_acc = 1'b1;
    if (cut) begin
      rst_n = 1'b0;
      @(negedge clock);
      check("reset", {ao, ind, ien, xa, cp}, 32'h0);
      rst_n = 1'b1;
      {st, cr, ce, sc, in_acc} = 5'h00;
      return;
    end
    lo = ex ? a[13:0] : exp_map(a, md, w, 1'b0);
    check("row addr", ao, {a[27:14], lo});
    check("row flags", {cp, xa, ien}, {1'b0, ex, en});
    if (en) check("row ind", ind, 32'h0);
    dc = ($urandom % 4) != 0;
    cr = dc ? 1'b1 : 1'($urandom);
    ce = !dc;
    if (dc) begin
      @(negedge clock);
      cr = 1'b0;
      ce = 1'b1;
      lo = ex ? a[13:0] : exp_map(a, md, w, 1'b1);
      check("col addr", ao, {a[27:14], lo});
      check("col flags", {cp, xa, ien}, {1'b1, ex, en});
      if (en) check("col ind", ind, sd ? sc : 1'b1);
    end
    @(negedge clock);
    {st, cr, ce, sc, in_acc} = 5'h00;
    check("idle", {ao, cp, xa}, {la, 2'b00});
    if (en) check("idle ind", ind, 32'h0);
    check("bank pins", bc, 32'h0);
    check("dram row", mrow, ex ? a[13:0] : exp_map(a, md, w, 1'b0));
    if (dc) check("dram col", mcol, lo);
  endtask : run_access

  // ----------------------------------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      stop_test();
    end
  end

  // stimulus
  initial begin
    {rst_n, gext, frc, st, cr, ce, sc, in_acc} = 8'h00;
    {csx, csm, css, csw, idx, la} = '0;
    void'($urandom(32'h57bc6674));
    repeat (10) @(negedge clock);
    check("reset", {ao, ind, ien, xa, cp}, 32'h0);
    rst_n = 1'b1;
    for (int i = 0; i < 300; i++) run_access(i, i == 150);
    stop_test();
  end
endmodule : tb_top
